// ===== pll_ctl_pkg.sv
// Constants, register map and carrier structs for the analog loop control block.
// Assumes a 32-bit APB slave, word-aligned; byte address = 4 x register index.
package pll_ctl_pkg;

    // ******************************************
    // Bus geometry
    // ******************************************
    localparam int          ADDR_W     = 16;          // Byte address width
    localparam int          IDX_W      = 14;          // Register index width

    // ******************************************
    // Register indices, channel 1 in the upper slot
    // ******************************************
    localparam logic [1:0][IDX_W-1:0] PUMP_IDX = {14'h1480, 14'h1080};
    localparam logic [1:0][IDX_W-1:0] DIV_IDX  = {14'h1481, 14'h1081};
    localparam logic [1:0][IDX_W-1:0] FILT_IDX = {14'h1482, 14'h1082};
    localparam logic [1:0][IDX_W-1:0] OFS_IDX  = {14'h1483, 14'h1083};
    localparam logic [1:0][IDX_W-1:0] CTRL_IDX = {14'h2200, 14'h2100};
    localparam logic [1:0][IDX_W-1:0] STS_IDX  = {14'h3200, 14'h3100};
    localparam logic [1:0][IDX_W-1:0] EVT_IDX  = {14'h3019, 14'h3014};
    localparam logic [1:0][IDX_W-1:0] CLR_IDX  = {14'h2014, 14'h200F};
    localparam logic [IDX_W-1:0]      CALL_IDX = 14'h2000; // Global calibrate
    localparam logic [IDX_W-1:0]      MFP_IDX  = 14'h2F00; // Multifunction pin source

    // ******************************************
    // Field positions
    // ******************************************
    localparam int          CAL_BIT    = 1;           // Calibrate bit in control regs
    localparam int          MAN_BIT    = 7;           // Manual pump mode
    localparam int          OFS_EN_BIT = 0;           // Offset enable
    localparam int          OFS_NEG_BIT = 3;          // Offset polarity
    localparam int          OFS_MAG_LO = 1;           // Offset magnitude [2:1]
    localparam int          ZR_LO      = 5;           // Zero resistor [7:5]
    localparam int          PC_LO      = 2;           // Pole capacitor [4:2]
    localparam int          SPR_LO     = 0;           // Second pole resistor [1:0]
    localparam int          STS_LOCK_POS = 3;         // Lock in status reg
    localparam int          STS_DONE_POS = 4;         // Done in status reg
    localparam int          STS_BUSY_POS = 5;         // Busy in status reg

    // Index of each analog status input inside its vector
    localparam int          A_BUSY     = 0;
    localparam int          A_DONE     = 1;
    localparam int          A_LOCK     = 2;

    // Latched event bit positions
    localparam int          EV_START   = 0;
    localparam int          EV_CMPL    = 1;
    localparam int          EV_LOCKED  = 2;
    localparam int          EV_UNLOCK  = 3;

    // ******************************************
    // Reset values
    // ******************************************
    localparam logic [7:0]  PUMP_RST   = 8'h90;       // Manual, 16 x 8 uA
    localparam logic [7:0]  DIV_RST    = 8'h00;       // Reads as ratio one
    localparam logic [7:0]  FILT_RST   = 8'hE0;       // Zero res 7, others 0
    localparam logic [7:0]  OFS_RST    = 8'h03;       // On, 25 %, positive
    localparam logic [6:0]  ICP_MAX    = 7'h7F;       // 1016 uA in 8 uA steps
    localparam logic [7:0]  AUTO_LIMIT = 8'h3F;       // Largest divider with scaled pump

    // ******************************************
    // Carriers
    // ******************************************
    typedef enum logic [2:0] {
        MFP_OFF   = 3'b000,
        MFP_BUSY0 = 3'b001,
        MFP_LOCK0 = 3'b010,
        MFP_BUSY1 = 3'b011,
        MFP_LOCK1 = 3'b100
    } mfp_src_e;

    // Live status coming from one analog loop
    typedef struct packed {
        logic       lock;         // Frequency locked
        logic       cal_done;     // Calibration finished
        logic       cal_busy;     // Calibration running
    } analog_sts_s;

    // Settings driven into one analog loop
    typedef struct packed {
        logic       cal_start;            // One-cycle calibration kick
        logic       pump_manual;          // Manual pump mode
        logic [6:0] pump_code;            // Effective pump current, 8 uA units
        logic       ofs_en;               // Offset current on
        logic       ofs_neg;              // Offset current negative
        logic [6:0] ofs_code;             // Offset magnitude, 8 uA units
        logic [7:0] fb_ratio;             // Feedback divide ratio, 1..255
        logic [2:0] zero_resistor;        // 250 ohm steps
        logic [2:0] pole_capacitor;       // 8 pF + 16 pF per step
        logic [1:0] second_pole_resistor; // 200/250/333/500 ohm
    } analog_ctl_s;

endpackage

// ===== analog_pll_control_status.sv
// Control and status logic for two analog loop channels, APB register slave.
// Assumes analog status inputs are asynchronous to pclk; settings go out as flops.
// Each register is one byte of a 32-bit word.
// pready is tied high: no wait states.
// Functional notes
// RQ1: Calibrate bit write of one starts calibration.
// RQ2: Software must write calibrate bit back zero.
// RQ3: Calibrate-all starts both channels and system PLL.
// RQ4: Status bits 5:4 show live busy, done.
// RQ5: Latched started/completed flags set on busy/done.
// RQ6: Started/completed flags cleared via clear bits 1:0.
// RQ7: Busy and lock routable to multifunction pin.
// RQ8: Divider ratio equals field; zero means one.
// RQ9: Status bit 3 shows live lock.
// RQ10: Latched locked/unlocked flags on lock transitions.
// RQ11: Locked/unlocked flags cleared via clear bits 3:2.
// RQ12: Pump bit 7 selects manual, reset manual.
// RQ13: Manual current is field times 8 uA.
// RQ14: Auto current M x 16 uA, max above 63.
// RQ15: Offset bit 0 enables offset, reset on.
// RQ16: Offset bit 3 sets polarity, zero positive.
// RQ17: Offset bits 2:1 pick 50/25/12.5/6.25 percent.
// RQ18: Offset truncated to whole 8 uA steps.
// RQ19: Zero resistor bits 7:5, 250 ohm steps.
// RQ20: Pole capacitor bits 4:2, 8 pF + 16/step.
// RQ21: Second pole resistor bits 1:0 selects four values.
// RQ22: Software should keep manual pump mode defaults.
// RQ23: Clear write one resets flag, zero keeps.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module analog_pll_control_status
    import pll_ctl_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    input  wire analog_sts_s [1:0]        analog_sts,
    output analog_ctl_s [1:0]             analog_ctl,
    output logic                          sys_cal_start,
    output logic                          multifunction_pin
);

    // ******************************************
    // State
    // ******************************************
    // Per channel storage: registers, synchroniser and latched events
    typedef struct packed {
        logic [7:0]  pump;       // Pump control register
        logic [7:0]  div;        // Feedback divider register
        logic [7:0]  filt;       // Loop filter select register
        logic [7:0]  ofs;        // Offset current register
        logic        cal_bit;    // Calibrate bit, held as written
        logic [2:0]  sync1;      // First synchroniser stage
        logic [2:0]  sync2;      // Second stage, the live status
        logic [2:0]  prev;       // Delayed copy for edge detection
        logic [3:0]  evt;        // Latched events
        analog_ctl_s ctl;        // Registered analog settings
    } chan_s;

    // Whole block state
    typedef struct packed {
        chan_s [1:0] ch;         // Two channels
        logic        cal_all;    // Global calibrate bit, held as written
        logic        sys_cal;    // System PLL calibration kick
        mfp_src_e    mfp_sel;    // Multifunction pin source
        logic        mfp;        // Multifunction pin level
        logic [31:0] rdata;      // Read data, loaded in setup phase
    } state_s;

    state_s                  q;         // Registered state
    state_s                  d;         // Next state
    logic [IDX_W-1:0]        idx;       // Register index of this access
    logic                    wr;        // Write takes effect this edge
    logic                    rd_setup;  // Read setup phase
    logic                    hit;       // Index is mapped

    // ******************************************
    // Bus decode
    // ******************************************
    // Zero wait states: every access completes in its first access cycle
    assign idx      = paddr[ADDR_W-1:2];
    assign wr       = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~hit;

    // Unmapped index: pslverr, reads zero.
    // Status and event registers ignore writes.

    // Mapped address check
    always_comb begin
        hit = (idx == CALL_IDX) || (idx == MFP_IDX);
        for (int i = 0; i < 2; i++) begin
            // Any of the channel's registers
            if (idx == PUMP_IDX[i] || idx == DIV_IDX[i] || idx == FILT_IDX[i] ||
                idx == OFS_IDX[i] || idx == CTRL_IDX[i] || idx == STS_IDX[i] ||
                idx == EVT_IDX[i] || idx == CLR_IDX[i]) begin
                hit = 1'b1;
            end
        end
    end

    // ******************************************
    // Next state
    // ******************************************
    // Register writes, event latching, derived analog settings, read mux
    always_comb begin
        logic       all_kick;
        logic [2:0] rise;
        logic [2:0] fall;
        logic [3:0] set;
        logic [3:0] clr;
        logic [7:0] ratio;
        logic [6:0] icp;
        logic [2:0] shamt;
        // Scratch values start defined
        all_kick = 1'b0;
        rise = 3'h0;
        fall = 3'h0;
        set = 4'h0;
        clr = 4'h0;
        ratio = 8'h00;
        icp = 7'h00;
        shamt = 3'h0;

        // Held state by default
        d        = q;
        d.sys_cal = 1'b0;
        // Calibrate-all write kicks both loops and the system PLL
        all_kick = wr && idx == CALL_IDX && pwdata[CAL_BIT]; // RQ3
        if (wr && idx == CALL_IDX) begin
            d.cal_all = pwdata[CAL_BIT];
            d.sys_cal = pwdata[CAL_BIT]; // RQ3
        end
        // Source select for the multifunction pin
        if (wr && idx == MFP_IDX) begin
            d.mfp_sel = mfp_src_e'(pwdata[2:0]);
        end
        for (int i = 0; i < 2; i++) begin
            // Two-stage synchroniser; only the second stage feeds logic
            d.ch[i].sync1 = {analog_sts[i].lock, analog_sts[i].cal_done,
                             analog_sts[i].cal_busy};
            d.ch[i].sync2 = q.ch[i].sync1;
            d.ch[i].prev  = q.ch[i].sync2;
            rise = q.ch[i].sync2 & ~q.ch[i].prev;
            fall = ~q.ch[i].sync2 & q.ch[i].prev;
            // Event sources
            set = '0;
            set[EV_START]  = rise[A_BUSY];  // RQ5
            set[EV_CMPL]   = rise[A_DONE];  // RQ5
            set[EV_LOCKED] = rise[A_LOCK];  // RQ10
            set[EV_UNLOCK] = fall[A_LOCK];  // RQ10
            // Write-one-to-clear; zeros leave flags alone
            clr = (wr && idx == CLR_IDX[i]) ? pwdata[3:0] : 4'h0; // RQ23
            // A new event in the clearing cycle survives the clear
            d.ch[i].evt = (q.ch[i].evt & ~clr) | set; // RQ6 RQ11

            // Plain register writes; low byte kept
            if (wr && idx == PUMP_IDX[i]) begin
                d.ch[i].pump = pwdata[7:0];
            end
            if (wr && idx == DIV_IDX[i]) begin
                d.ch[i].div = pwdata[7:0];
            end
            if (wr && idx == FILT_IDX[i]) begin
                d.ch[i].filt = pwdata[7:0];
            end
            if (wr && idx == OFS_IDX[i]) begin
                d.ch[i].ofs = pwdata[7:0];
            end
            // Calibrate bit is stored as written, not self-clearing
            if (wr && idx == CTRL_IDX[i]) begin
                d.ch[i].cal_bit = pwdata[CAL_BIT];
            end
            d.ch[i].ctl.cal_start = (wr && idx == CTRL_IDX[i] && pwdata[CAL_BIT]) // RQ1
                                    || all_kick; // RQ3

            // Divider ratio: zero behaves as one
            ratio = (d.ch[i].div == 8'h00) ? 8'h01 : d.ch[i].div; // RQ8
            d.ch[i].ctl.fb_ratio = ratio;

            // Pump current: manual field, or scaled from the divider in auto
            // Auto scaling stops at ratio 63
            d.ch[i].ctl.pump_manual = d.ch[i].pump[MAN_BIT]; // RQ12
            if (d.ch[i].pump[MAN_BIT]) begin
                icp = d.ch[i].pump[6:0]; // RQ13
            end else if (ratio <= AUTO_LIMIT) begin
                icp = {ratio[5:0], 1'b0}; // RQ14
            end else begin
                icp = ICP_MAX; // RQ14
            end
            d.ch[i].ctl.pump_code = icp;
            // Offset: shift by magnitude + 1 halves the current per step,
            // and the shift drops any part step, so sign never biases rounding
            shamt = {1'b0, d.ch[i].ofs[OFS_MAG_LO +: 2]} + 3'd1; // RQ17
            d.ch[i].ctl.ofs_code = icp >> shamt; // RQ18
            d.ch[i].ctl.ofs_en   = d.ch[i].ofs[OFS_EN_BIT]; // RQ15
            d.ch[i].ctl.ofs_neg  = d.ch[i].ofs[OFS_NEG_BIT]; // RQ16
            // Loop filter selects go out unchanged
            d.ch[i].ctl.zero_resistor        = d.ch[i].filt[ZR_LO +: 3]; // RQ19
            d.ch[i].ctl.pole_capacitor       = d.ch[i].filt[PC_LO +: 3]; // RQ20
            d.ch[i].ctl.second_pole_resistor = d.ch[i].filt[SPR_LO +: 2]; // RQ21
        end

        // Multifunction pin follows the selected live status
        // Registered: lags status one edge
        unique case (q.mfp_sel)
            MFP_OFF:   d.mfp = 1'b0;
            MFP_BUSY0: d.mfp = q.ch[0].sync2[A_BUSY]; // RQ7
            MFP_LOCK0: d.mfp = q.ch[0].sync2[A_LOCK]; // RQ7
            MFP_BUSY1: d.mfp = q.ch[1].sync2[A_BUSY];
            MFP_LOCK1: d.mfp = q.ch[1].sync2[A_LOCK];
            default:   d.mfp = 1'b0; // Software may write unused codes
        endcase

        // Read data is captured in the setup phase; unmapped reads zero
        // Loaded once per read transfer
        if (rd_setup) begin
            d.rdata = 32'h0000_0000;
            if (idx == CALL_IDX) begin
                d.rdata[CAL_BIT] = q.cal_all;
            end
            if (idx == MFP_IDX) begin
                d.rdata[2:0] = q.mfp_sel;
            end
            for (int i = 0; i < 2; i++) begin
                if (idx == PUMP_IDX[i]) begin
                    d.rdata[7:0] = q.ch[i].pump;
                end
                if (idx == DIV_IDX[i]) begin
                    d.rdata[7:0] = q.ch[i].div;
                end
                if (idx == FILT_IDX[i]) begin
                    d.rdata[7:0] = q.ch[i].filt;
                end
                if (idx == OFS_IDX[i]) begin
                    d.rdata[7:0] = q.ch[i].ofs;
                end
                if (idx == CTRL_IDX[i]) begin
                    d.rdata[CAL_BIT] = q.ch[i].cal_bit;
                end
                // Live status view
                if (idx == STS_IDX[i]) begin
                    d.rdata[STS_BUSY_POS] = q.ch[i].sync2[A_BUSY]; // RQ4
                    d.rdata[STS_DONE_POS] = q.ch[i].sync2[A_DONE]; // RQ4
                    d.rdata[STS_LOCK_POS] = q.ch[i].sync2[A_LOCK]; // RQ9
                end
                if (idx == EVT_IDX[i]) begin
                    d.rdata[3:0] = q.ch[i].evt; // RQ5 RQ10
                end
            end
        end
    end

    // ******************************************
    // State register
    // ******************************************
    // Reset settings feed the analog side from the first edge on
    // Derived codes reset too, never stale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            for (int i = 0; i < 2; i++) begin
                q.ch[i].pump <= PUMP_RST;
                q.ch[i].div  <= DIV_RST;
                q.ch[i].filt <= FILT_RST;
                q.ch[i].ofs  <= OFS_RST;
                q.ch[i].ctl.pump_manual <= PUMP_RST[MAN_BIT];
                q.ch[i].ctl.pump_code   <= PUMP_RST[6:0];
                q.ch[i].ctl.ofs_en      <= OFS_RST[OFS_EN_BIT];
                q.ch[i].ctl.ofs_code    <= PUMP_RST[6:0] >> 2;
                q.ch[i].ctl.fb_ratio    <= 8'h01;
                q.ch[i].ctl.zero_resistor <= FILT_RST[ZR_LO +: 3];
            end
        end else begin
            q <= d;
        end
    end

    // ******************************************
    // Outputs
    // ******************************************
    assign prdata            = q.rdata;
    assign sys_cal_start     = q.sys_cal;
    assign multifunction_pin = q.mfp;
    assign analog_ctl        = {q.ch[1].ctl, q.ch[0].ctl};

    // ******************************************
    // Assertions
    // ******************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Global kick reaches every loop next cycle
    cal_all_kick_a: assert property ( // RQ3
        wr && idx == CALL_IDX && pwdata[CAL_BIT] |=>
        sys_cal_start && analog_ctl[0].cal_start && analog_ctl[1].cal_start)
        else $error("calibrate-all did not kick all loops");

    for (genvar g = 0; g < 2; g++) begin : g_chk
        sequence busy_rise_s;
            q.ch[g].sync2[A_BUSY] && !q.ch[g].prev[A_BUSY];
        endsequence
        sequence lock_fall_s;
            !q.ch[g].sync2[A_LOCK] && q.ch[g].prev[A_LOCK];
        endsequence
        sequence lock_clear_s;
            wr && idx == CLR_IDX[g] && pwdata[EV_LOCKED];
        endsequence

        // Kick, then bit held
        cal_kick_a: assert property ( // RQ1
            wr && idx == CTRL_IDX[g] && pwdata[CAL_BIT] |=>
            analog_ctl[g].cal_start ##1 q.ch[g].cal_bit)
            else $error("calibrate write did not start calibration");

        // Status read is live
        status_read_a: assert property ( // RQ4
            rd_setup && idx == STS_IDX[g] |=>
            prdata[5:3] == {$past(q.ch[g].sync2[A_BUSY]), $past(q.ch[g].sync2[A_DONE]),
                            $past(q.ch[g].sync2[A_LOCK])})
            else $error("status read does not show live state");

        // Busy rise latches
        started_set_a: assert property ( // RQ5
            busy_rise_s |=> q.ch[g].evt[EV_START] [*2])
            else $error("started flag not latched");

        // Flag holds uncleared
        flag_hold_a: assert property ( // RQ23
            q.ch[g].evt[EV_CMPL] && !(wr && idx == CLR_IDX[g] && pwdata[EV_CMPL]) |=>
            q.ch[g].evt[EV_CMPL])
            else $error("completed flag lost without clear");

        // Clear with no new event
        lock_clear_a: assert property ( // RQ11
            lock_clear_s ##0 !(q.ch[g].sync2[A_LOCK] && !q.ch[g].prev[A_LOCK]) |=>
            !q.ch[g].evt[EV_LOCKED])
            else $error("locked flag not cleared");

        // Lock loss latches
        unlock_set_a: assert property ( // RQ10
            lock_fall_s |=> q.ch[g].evt[EV_UNLOCK])
            else $error("unlocked flag not latched");

        // Zero divides by one
        ratio_floor_a: assert property ( // RQ8
            analog_ctl[g].fb_ratio == ((q.ch[g].div == 8'h00) ? 8'h01 : q.ch[g].div))
            else $error("divide ratio wrong");

        // Auto pump saturates
        auto_pump_a: assert property ( // RQ14
            !analog_ctl[g].pump_manual && analog_ctl[g].fb_ratio > AUTO_LIMIT |->
            analog_ctl[g].pump_code == ICP_MAX)
            else $error("auto pump current not at maximum");

        // Offset is a shifted share
        offset_trunc_a: assert property ( // RQ18
            analog_ctl[g].ofs_code ==
            (analog_ctl[g].pump_code >> ({1'b0, q.ch[g].ofs[2:1]} + 3'd1)))
            else $error("offset current not truncated share");
    end

endmodule

// ===== testbench.sv
// Self-checking bench for the two-channel analog loop control block.
// Assumes a zero-wait APB slave and status inputs that pass two sync flops.
`timescale 1ns/100ps
module testbench import pll_ctl_pkg::*;;
    // ************************************************
    // Signals
    // ************************************************
    logic              pclk       = 1'b0;
    logic              presetn    = 1'b0;
    logic              psel       = 1'b0;
    logic              penable    = 1'b0;
    logic              pwrite     = 1'b0;
    logic [ADDR_W-1:0] paddr      = '0;
    logic [31:0]       pwdata     = '0;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    analog_sts_s [1:0] analog_sts = '0;   // Live analog status, driven by the bench
    analog_ctl_s [1:0] analog_ctl;
    logic              sys_cal_start;
    logic              multifunction_pin;
    int                mismatches = 0;
    int                checked    = 0;
    int                cycles     = 0;
    logic [31:0]       seed       = 32'h5293708D;
    logic [31:0]       rd;                // Data of the last read
    logic              err;               // Error flag of the last transfer
    logic [7:0]        pv, dv, ov, fv;    // Pump, divider, offset and filter values

    always #20 pclk = ~pclk;

    analog_pll_control_status dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .analog_sts(analog_sts),
        .analog_ctl(analog_ctl), .sys_cal_start(sys_cal_start),
        .multifunction_pin(multifunction_pin));

    // ************************************************
    // Helpers
    // ************************************************
    // Xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Settings the analog loop should see for given register bytes
    function automatic analog_ctl_s exp_ctl(logic [7:0] p, logic [7:0] d, logic [7:0] o,
                                            logic [7:0] f);
        analog_ctl_s e;
        logic [7:0]  r;
        r = (d == 8'h00) ? 8'h01 : d;
        e = '0;
        e.pump_manual = p[7];
        e.pump_code = p[7] ? p[6:0] : ((r <= 8'h3F) ? 7'(r * 8'h02) : 7'h7F);
        e.ofs_en = o[0];
        e.ofs_neg = o[3];
        // Shift truncates toward zero, sign kept apart
        e.ofs_code = e.pump_code >> ({1'b0, o[2:1]} + 3'h1);
        e.fb_ratio = r;
        e.zero_resistor = f[7:5];
        e.pole_capacitor = f[4:2];
        e.second_pole_resistor = f[1:0];
        return e;
    endfunction

    // Live level that the selected pin source should show
    function automatic logic exp_pin(int s, analog_sts_s [1:0] a);
        case (s)
            1: return a[0].cal_busy;
            2: return a[0].lock;
            3: return a[1].cal_busy;
            4: return a[1].lock;
            default: return 1'b0;
        endcase
    endfunction

    task automatic chk(string name, logic [39:0] exp, logic [39:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(logic wr, logic [IDX_W-1:0] idx, logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Hold until pready is seen at an edge
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, far above the roughly 660 cycles the run needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // ************************************************
    // Sequence
    // ************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        for (int c = 0; c < 2; c++) begin
            chk("ctl reset", 40'(exp_ctl(8'h90, 8'h00, 8'h03, 8'hE0)), 40'(analog_ctl[c]));
            apb(1'b0, PUMP_IDX[c], 8'h00);
            chk("pump reset", 40'h90, 40'(rd[7:0]));
        end
        $display("test reset done");
        // Random settings with divider corners 0, 63, 64 and 255 first
        for (int i = 0; i < 24; i++) begin
            pv = 8'(rnd());
            dv = (i == 0) ? 8'h00 : (i == 1) ? 8'h3F : (i == 2) ? 8'h40 : 8'(rnd());
            dv = (i == 3) ? 8'hFF : dv;
            ov = 8'(rnd() & 32'h0000000F);
            fv = 8'(rnd());
            apb(1'b1, PUMP_IDX[i % 2], pv);
            apb(1'b1, DIV_IDX[i % 2], dv);
            apb(1'b1, OFS_IDX[i % 2], ov);
            apb(1'b1, FILT_IDX[i % 2], fv);
            #1;
            chk("ctl", 40'(exp_ctl(pv, dv, ov, fv)), 40'(analog_ctl[i % 2]));
            apb(1'b0, DIV_IDX[i % 2], 8'h00);
            chk("div read", 40'(dv), 40'(rd));
            apb(1'b0, FILT_IDX[i % 2], 8'h00);
            chk("filter read", 40'(fv), 40'(rd));
        end
        // Back to manual defaults
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, PUMP_IDX[c], PUMP_RST);
            apb(1'b1, OFS_IDX[c], OFS_RST);
        end
        $display("test settings done");
        // Channel 0, channel 1, then calibrate-all
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, (c == 2) ? CALL_IDX : CTRL_IDX[c], 8'h02);
            #1;
            chk("cal kick", 40'({c != 0, c != 1, c == 2}),
                40'({analog_ctl[1].cal_start, analog_ctl[0].cal_start, sys_cal_start}));
            @(posedge pclk);
            #1;
            chk("cal pulse", 40'h0,
                40'({analog_ctl[1].cal_start, analog_ctl[0].cal_start, sys_cal_start}));
            apb(1'b1, (c == 2) ? CALL_IDX : CTRL_IDX[c], 8'h00);
        end
        $display("test calibrate done");
        for (int c = 0; c < 2; c++) begin
            @(posedge pclk);
            analog_sts[c] <= 3'b111;
            repeat (6) @(posedge pclk);
            apb(1'b0, STS_IDX[c], 8'h00);
            chk("status", 40'h7, 40'(rd[5:3]));
            apb(1'b0, EVT_IDX[c], 8'h00);
            chk("events", 40'h7, 40'(rd[3:0]));
            apb(1'b1, CLR_IDX[c], 8'h01);
            apb(1'b0, EVT_IDX[c], 8'h00);
            chk("clear start", 40'h6, 40'(rd[3:0]));
            @(posedge pclk);
            analog_sts[c] <= 3'b000;
            repeat (6) @(posedge pclk);
            apb(1'b0, EVT_IDX[c], 8'h00);
            chk("unlock event", 40'hE, 40'(rd[3:0]));
            apb(1'b0, STS_IDX[c], 8'h00);
            chk("status low", 40'h0, 40'(rd[5:3]));
            apb(1'b1, CLR_IDX[c], 8'h0F);
            apb(1'b0, EVT_IDX[c], 8'h00);
            chk("clear all", 40'h0, 40'(rd[3:0]));
        end
        $display("test events done");
        for (int s = 0; s < 10; s++) begin
            apb(1'b1, MFP_IDX, 8'(s % 5));
            @(posedge pclk);
            analog_sts <= 6'(rnd());
            repeat (6) @(posedge pclk);
            #1;
            chk("pin", 40'(exp_pin(s % 5, analog_sts)), 40'(multifunction_pin));
        end
        apb(1'b0, 14'h0001, 8'h00);
        chk("unmapped", 40'h100000000, 40'({err, rd}));
        $display("test pin and unmapped done");
        stop_test();
    end
endmodule
